/* hdl/speech_frame_field_parser.v */
// speech frame field parser with an ahb-lite register slave
//
// Contract
// - fields arrive and assemble msb first
// - 328 bits at 16.4, 488 at 24.4
// - 640 bits at 32
// - 960/1280/1920/2560 bits for 48-128
// - one core select bit at 24.4, 32
// - next bit picks hq or transform core
// - transform core reads two coder type bits
// - hq reads prior-lp bit, second if set
// - second bit picks 12.8 or 16 kHz
// - lp core at 32/64 uses joint index
// - lp at 32 reads extension layer bit
// - 48 kbps: transform core, no select bit
// - silence descriptor is always 48 bits
// - three descriptor formats by noise type flag
// - spectral descriptor: 1,2,1,7,37 bit fields
// - predictive descriptor: 1,1,1,3,29,7 bit fields
// - wideband predictive: 6 envelope bits
// - super-wideband: 4 energy, 2 unused bits
// - channel-aware frame is 264 bits
// - first 5 bits hold joint index
// - no redundancy: parse as ordinary frame; here still channel-aware kind and rate, partial fields zero
// - last three bits: partial copy type
// - two bits before: partial copy offset
// - bit split depends on type, max 60
`include "frame_parser_regs.vh"
module speech_frame_field_parser (
  input wire SYS_CLK,
  input wire RST_N,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire BIT_VALID,
  input wire BIT_DATA,
  input wire BIT_LAST,
  output reg FIELDS_VALID,
  output reg FRAME_ERROR,
  output reg [2:0] FRAME_KIND,
  output reg [3:0] FRAME_RATE,
  output reg [1:0] CORE,
  output reg [1:0] BANDWIDTH,
  output reg [4:0] CODER_TYPE,
  output reg PRIOR_LP,
  output reg HQ_RATE_16K,
  output reg EXT_FREQ,
  output reg PARTIAL_PRESENT,
  output reg [2:0] PARTIAL_TYPE,
  output reg [2:0] PARTIAL_OFFSET,
  output reg [6:0] PARTIAL_BITS,
  output reg [8:0] PRIMARY_BITS,
  output reg [2:0] SID_HANGOVER,
  output reg [6:0] SID_FIELD_A,
  output reg [36:0] SID_FIELD_B,
  output reg [6:0] SID_FIELD_C
);
  parameter LEN_WIDTH = 12;
  parameter HEAD_BITS = 48;
  localparam S_IDLE = 3'b001;
  localparam S_BITS = 3'b010;
  localparam S_EMIT = 3'b100;

  reg [2:0] state_reg;
  reg [LEN_WIDTH-1:0] len_reg;
  reg [HEAD_BITS-1:0] head_reg;
  reg [4:0] tail_reg;
  reg [1:0] ctrl_reg;
  reg [15:0] frames_reg;
  reg [15:0] errors_reg;
  reg last_err_reg;
  reg [LEN_WIDTH-1:0] last_len_reg;
  reg ph_write_reg;
  reg [7:0] ph_addr_reg;

  ////////////////////////////////////////////////////////////////////////
  // bit collection
  wire take_bit = ctrl_reg[`CTRL_ENABLE] & BIT_VALID & ~state_reg[2];
  wire len_full = &len_reg;

  // frame walk: gather bits, then decode one cycle after the last bit
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= S_IDLE;
      len_reg <= {LEN_WIDTH{1'b0}};
      head_reg <= {HEAD_BITS{1'b0}};
      tail_reg <= 5'h00;
    end else begin
      case (state_reg)
        S_IDLE, S_BITS: begin
          if (take_bit) begin
            if (len_reg < HEAD_BITS)
              head_reg <= {head_reg[HEAD_BITS-2:0], BIT_DATA};
            tail_reg <= {tail_reg[3:0], BIT_DATA};
            if (!len_full)
              len_reg <= len_reg + 1'b1;
            state_reg <= BIT_LAST ? S_EMIT : S_BITS;
          end
        end
        S_EMIT: begin
          len_reg <= {LEN_WIDTH{1'b0}};
          head_reg <= {HEAD_BITS{1'b0}};
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field decode from first 48 and last 5 bits
  wire [HEAD_BITS-1:0] h = head_reg;
  reg ok;
  reg [2:0] kind_next;
  reg [3:0] rate_next;
  reg [1:0] core_next;
  reg [1:0] bw_next;
  reg [4:0] ct_next;
  reg prior_next;
  reg hq16_next;
  reg ext_next;
  reg pp_next;
  reg [2:0] ptype_next;
  reg [2:0] poff_next;
  reg [6:0] pbits_next;
  reg [2:0] hang_next;
  reg [6:0] sa_next;
  reg [36:0] sb_next;
  reg [6:0] sc_next;

  // hq switching bits sit at position p and p+1
  task hq_switch;
    input integer p;
    begin
      core_next = `CORE_HQ;
      prior_next = h[47-p];
      hq16_next = h[47-p] & h[46-p];
    end
  endtask

  always @* begin
    ok = 1'b1;
    kind_next = `KIND_NORMAL;
    rate_next = `RATE_16K4;
    core_next = `CORE_LP;
    bw_next = 2'h0;
    ct_next = 5'h00;
    prior_next = 1'b0;
    hq16_next = 1'b0;
    ext_next = 1'b0;
    pp_next = 1'b0;
    ptype_next = 3'h0;
    poff_next = 3'h0;
    pbits_next = `PARTIAL_NONE_BITS;
    hang_next = 3'h0;
    sa_next = 7'h00;
    sb_next = 37'h0;
    sc_next = 7'h00;
    case (len_reg)
      `LEN_16K4: begin
        rate_next = `RATE_16K4;
        bw_next = h[47:46];
        ct_next = {2'h0, h[44:42]};
      end
      `LEN_24K4: begin
        rate_next = `RATE_24K4;
        bw_next = h[47:46];
        if (!h[44]) begin
          ct_next = {3'h0, h[43:42]};
        end else if (h[43]) begin
          core_next = `CORE_TRANSFORM;
          ct_next = {3'h0, h[42:41]};
        end else begin
          hq_switch(5);
        end
      end
      `LEN_32K: begin
        rate_next = `RATE_32K;
        if (!h[47]) begin
          ct_next = {1'b0, h[46:43]};
          ext_next = h[42];
        end else if (h[46]) begin
          core_next = `CORE_TRANSFORM;
          ct_next = {3'h0, h[45:44]};
        end else begin
          hq_switch(2);
        end
      end
      `LEN_48K: begin
        rate_next = `RATE_48K;
        core_next = `CORE_TRANSFORM;
        bw_next = h[47:46];
        ct_next = {2'h0, h[44:42]};
      end
      `LEN_64K: begin
        rate_next = `RATE_64K;
        if (!h[47])
          ct_next = {1'b0, h[46:43]};
        else
          hq_switch(1);
      end
      `LEN_96K, `LEN_128K: begin
        rate_next = (len_reg == `LEN_96K) ? `RATE_96K : `RATE_128K;
        core_next = `CORE_TRANSFORM;
        bw_next = h[47:46];
        ct_next = {2'h0, h[44:42]};
      end
      `LEN_SID: begin
        rate_next = `RATE_SID;
        if (h[47]) begin
          kind_next = `KIND_SID_SPECTRAL;
          bw_next = h[46:45];
          hq16_next = h[44];
          sa_next = h[43:37];
          sb_next = h[36:0];
        end else begin
          kind_next = h[46] ? `KIND_SID_PRED_SUPER : `KIND_SID_PRED_WIDE;
          bw_next = {1'b0, h[46]};
          hq16_next = h[45];
          hang_next = h[44:42];
          sb_next = {8'h00, h[41:13]};
          sa_next = h[12:6];
          if (h[46])
            sc_next = {3'h0, h[5:2]};
          else
            sc_next = {1'b0, h[5:0]};
        end
      end
      `LEN_CA: begin
        rate_next = `RATE_CA;
        kind_next = `KIND_CA;
        ct_next = h[47:43];
        pp_next = h[47];
        if (h[47]) begin
          ptype_next = tail_reg[2:0];
          case (tail_reg[4:3])
            2'h0: poff_next = 3'h2;
            2'h1: poff_next = 3'h3;
            2'h2: poff_next = 3'h5;
            default: poff_next = 3'h7;
          endcase
          case (tail_reg[2:0])
            3'h0: pbits_next = `PARTIAL_NONE_BITS;
            3'h1: pbits_next = `PARTIAL_FREQ_BITS;
            3'h2: pbits_next = `PARTIAL_TIME_ONE_BITS;
            3'h3: pbits_next = `PARTIAL_TIME_TWO_BITS;
            3'h4: pbits_next = `PARTIAL_ALL_PRED_BITS;
            3'h5: pbits_next = `PARTIAL_NON_PRED_BITS;
            3'h6: pbits_next = `PARTIAL_GEN_PRED_BITS;
            default: pbits_next = `PARTIAL_NOISE_BITS;
          endcase
        end
      end
      default: ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // result outputs, fields held until the next good frame
  wire emit = state_reg[2];

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIELDS_VALID <= 1'b0;
      FRAME_ERROR <= 1'b0;
      FRAME_KIND <= 3'h0;
      FRAME_RATE <= 4'h0;
      CORE <= 2'h0;
      BANDWIDTH <= 2'h0;
      CODER_TYPE <= 5'h00;
      PRIOR_LP <= 1'b0;
      HQ_RATE_16K <= 1'b0;
      EXT_FREQ <= 1'b0;
      PARTIAL_PRESENT <= 1'b0;
      PARTIAL_TYPE <= 3'h0;
      PARTIAL_OFFSET <= 3'h0;
      PARTIAL_BITS <= 7'h00;
      PRIMARY_BITS <= 9'h000;
      SID_HANGOVER <= 3'h0;
      SID_FIELD_A <= 7'h00;
      SID_FIELD_B <= 37'h0;
      SID_FIELD_C <= 7'h00;
      last_err_reg <= 1'b0;
      last_len_reg <= {LEN_WIDTH{1'b0}};
    end else begin
      FIELDS_VALID <= emit & ok;
      FRAME_ERROR <= emit & ~ok;
      if (emit) begin
        last_err_reg <= ~ok;
        last_len_reg <= len_reg;
      end
      if (emit & ok) begin
        FRAME_KIND <= kind_next;
        FRAME_RATE <= rate_next;
        CORE <= core_next;
        BANDWIDTH <= bw_next;
        CODER_TYPE <= ct_next;
        PRIOR_LP <= prior_next;
        HQ_RATE_16K <= hq16_next;
        EXT_FREQ <= ext_next;
        PARTIAL_PRESENT <= pp_next;
        PARTIAL_TYPE <= ptype_next;
        PARTIAL_OFFSET <= poff_next;
        PARTIAL_BITS <= pbits_next;
        PRIMARY_BITS <= pp_next ? (`CA_PAYLOAD_BITS - `CA_TRAILER_BITS - {2'h0, pbits_next})
                                : 9'h000;
        SID_HANGOVER <= hang_next;
        SID_FIELD_A <= sa_next;
        SID_FIELD_B <= sb_next;
        SID_FIELD_C <= sc_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay
  wire ap_valid = HSEL & HREADY & HTRANS[1];
  reg [31:0] rd_next;

  // read mux from the address phase
  always @* begin
    case (HADDR[7:0])
      `REG_CTRL: rd_next = {30'h0, ctrl_reg};
      `REG_STATUS: rd_next = {4'h0, last_len_reg, 13'h0, last_err_reg, state_reg[1], emit};
      `REG_FIELDS: rd_next = {4'h0, FRAME_RATE, 1'b0, FRAME_KIND, 2'h0, CORE, 2'h0, BANDWIDTH,
                              1'b0, CODER_TYPE, 3'h0, PRIOR_LP, HQ_RATE_16K, EXT_FREQ};
      `REG_PARTIAL: rd_next = {PARTIAL_PRESENT, PARTIAL_TYPE, 1'b0, PARTIAL_OFFSET, 1'b0,
                               PARTIAL_BITS, 7'h00, PRIMARY_BITS};
      `REG_FRAMES: rd_next = {16'h0, frames_reg};
      `REG_ERRORS: rd_next = {16'h0, errors_reg};
      default: rd_next = 32'h0;
    endcase
  end

  // address phase capture and read data
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_write_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
      HRDATA <= 32'h0;
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      ph_write_reg <= ap_valid & HWRITE;
      ph_addr_reg <= HADDR[7:0];
      if (ap_valid & ~HWRITE)
        HRDATA <= rd_next;
    end
  end

  // control register and counters
  wire wr_ctrl = ph_write_reg & (ph_addr_reg == `REG_CTRL);
  wire clear = wr_ctrl & HWDATA[`CTRL_CLEAR];

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= `CTRL_RESET;
      frames_reg <= 16'h0;
      errors_reg <= 16'h0;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= {1'b0, HWDATA[`CTRL_ENABLE]};
      if (emit & ok)
        frames_reg <= frames_reg + 16'h1;
      else if (clear)
        frames_reg <= 16'h0;
      if (emit & ~ok)
        errors_reg <= errors_reg + 16'h1;
      else if (clear)
        errors_reg <= 16'h0;
    end
  end
endmodule

/* hdl/frame_parser_regs.vh */
// offsets, fields, frame sizes and codes for the speech frame field parser
`ifndef FRAME_PARSER_REGS_VH
`define FRAME_PARSER_REGS_VH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_FIELDS 8'h08
`define REG_PARTIAL 8'h0C
`define REG_FRAMES 8'h10
`define REG_ERRORS 8'h14
`define CTRL_ENABLE 0
`define CTRL_CLEAR 1
`define CTRL_RESET 2'h1
`define LEN_SID 12'h030
`define LEN_CA 12'h108
`define LEN_16K4 12'h148
`define LEN_24K4 12'h1E8
`define LEN_32K 12'h280
`define LEN_48K 12'h3C0
`define LEN_64K 12'h500
`define LEN_96K 12'h780
`define LEN_128K 12'hA00
`define RATE_16K4 4'h0
`define RATE_24K4 4'h1
`define RATE_32K 4'h2
`define RATE_48K 4'h3
`define RATE_64K 4'h4
`define RATE_96K 4'h5
`define RATE_128K 4'h6
`define RATE_SID 4'h7
`define RATE_CA 4'h8
`define KIND_NORMAL 3'h0
`define KIND_SID_SPECTRAL 3'h1
`define KIND_SID_PRED_WIDE 3'h2
`define KIND_SID_PRED_SUPER 3'h3
`define KIND_CA 3'h4
`define CORE_LP 2'h0
`define CORE_HQ 2'h1
`define CORE_TRANSFORM 2'h2
`define PARTIAL_NONE_BITS 7'h00
`define PARTIAL_FREQ_BITS 7'h3C
`define PARTIAL_TIME_ONE_BITS 7'h28
`define PARTIAL_TIME_TWO_BITS 7'h28
`define PARTIAL_ALL_PRED_BITS 7'h0C
`define PARTIAL_NON_PRED_BITS 7'h1C
`define PARTIAL_GEN_PRED_BITS 7'h3C
`define PARTIAL_NOISE_BITS 7'h1E
`define CA_TRAILER_BITS 9'h00A
`define CA_PAYLOAD_BITS 9'h103
`endif

/* dv/frame_parser_props.sv */
// checker for the frame parser ports
`include "frame_parser_regs.vh"
module frame_parser_props (
  input wire SYS_CLK,
  input wire RST_N,
  input wire HRESP,
  input wire HREADYOUT,
  input wire BIT_VALID,
  input wire BIT_LAST,
  input wire FIELDS_VALID,
  input wire FRAME_ERROR,
  input wire [2:0] FRAME_KIND,
  input wire [3:0] FRAME_RATE,
  input wire PARTIAL_PRESENT,
  input wire [2:0] PARTIAL_TYPE,
  input wire [2:0] PARTIAL_OFFSET,
  input wire [6:0] PARTIAL_BITS
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////
  // result pulses and channel-aware decode
  wire done = FIELDS_VALID || FRAME_ERROR;
  wire ca = FIELDS_VALID && FRAME_KIND == `KIND_CA;
  a_pulse_one_cycle: assert property (done |=> !done)
    else $error("result pulse longer than one cycle");
  a_result_exclusive: assert property (!(FIELDS_VALID && FRAME_ERROR))
    else $error("good and bad result together");
  a_answer_after_last: assert property (done |-> $past(BIT_VALID && BIT_LAST, 2))
    else $error("result not two edges after last bit");
  a_error_keeps_fields: assert property (FRAME_ERROR |-> $stable(FRAME_RATE))
    else $error("fields changed on a bad frame");
  a_sid_rate_code: assert property (FIELDS_VALID && FRAME_KIND inside {3'h1, 3'h2, 3'h3}
    |-> FRAME_RATE == `RATE_SID)
    else $error("descriptor without descriptor rate");
  a_offset_legal: assert property (ca && PARTIAL_PRESENT
    |-> PARTIAL_OFFSET inside {3'h2, 3'h3, 3'h5, 3'h7})
    else $error("partial offset outside 2,3,5,7");
  a_no_partial_zero: assert property (ca && !PARTIAL_PRESENT
    |-> PARTIAL_TYPE == 3'h0 && PARTIAL_OFFSET == 3'h0)
    else $error("partial fields set without redundancy");
  a_partial_max: assert property (FIELDS_VALID |-> PARTIAL_BITS <= 7'h3C)
    else $error("partial copy over 60 bits");
  a_bus_okay: assert property ($past(RST_N) |-> HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  c_partial: cover property (ca && PARTIAL_PRESENT);
  c_error: cover property (FRAME_ERROR);
  c_super: cover property (FIELDS_VALID && FRAME_KIND == `KIND_SID_PRED_SUPER);
endmodule

/* dv/frame_sink.sv */
// jitter buffer side: takes each result pulse in its cycle
module frame_sink (
  input wire clk,
  input wire rst_n,
  input wire fields_valid,
  input wire frame_error,
  output int n_good,
  output int n_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  // count decoded and refused frames
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_good <= 0;
      n_bad <= 0;
    end else begin
      n_good <= n_good + int'(fields_valid);
      n_bad <= n_bad + int'(frame_error);
    end
  end
endmodule

/* dv/speech_frame_field_parser_test.sv */
// self-checking bench for the speech frame field parser
`include "frame_parser_regs.vh"
module speech_frame_field_parser_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic err;
    logic [3:0] rate;
    logic [2:0] kind, h, typ, off;
    logic [1:0] what;
    logic [6:0] a, c;
    logic [36:0] b;
    logic pres;
    logic cores, prior, hq16, ext;
    logic [1:0] core, bw;
    logic [4:0] ct;
    logic [6:0] pb;
    logic [8:0] pri;
  } exp_t;
  logic SYS_CLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0;
  logic BIT_VALID = 0, BIT_DATA = 0, BIT_LAST = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, d, seed = 32'h5D;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = 0;
  logic [63:0] w;
  wire [31:0] HRDATA;
  wire HREADY, HREADYOUT, HRESP, FIELDS_VALID, FRAME_ERROR, PRIOR_LP, HQ_RATE_16K;
  wire EXT_FREQ, PARTIAL_PRESENT;
  wire [2:0] FRAME_KIND, PARTIAL_TYPE, PARTIAL_OFFSET, SID_HANGOVER;
  wire [3:0] FRAME_RATE;
  wire [1:0] CORE, BANDWIDTH;
  wire [4:0] CODER_TYPE;
  wire [6:0] PARTIAL_BITS, SID_FIELD_A, SID_FIELD_C;
  wire [8:0] PRIMARY_BITS;
  wire [36:0] SID_FIELD_B;
  int n_errors = 0, checked = 0, n_good, n_bad;
  int lens[7] = '{328, 488, 640, 960, 1280, 1920, 2560};
  logic [2:0] offs[4] = '{3'h2, 3'h3, 3'h5, 3'h7};
  logic [3:0] rt[12] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h6, 4'h0};
  logic [6:0] pbt[8] = '{`PARTIAL_NONE_BITS, `PARTIAL_FREQ_BITS, `PARTIAL_TIME_ONE_BITS,
    `PARTIAL_TIME_TWO_BITS, `PARTIAL_ALL_PRED_BITS, `PARTIAL_NON_PRED_BITS,
    `PARTIAL_GEN_PRED_BITS, `PARTIAL_NOISE_BITS};
  int c;
  logic [1:0] sw;
  logic [47:0] hd;
  exp_t expq[$];
  exp_t x, y;
  assign HREADY = HREADYOUT;
  always #20 SYS_CLK = ~SYS_CLK;
  speech_frame_field_parser dut (.SYS_CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .BIT_VALID, .BIT_DATA,
    .BIT_LAST, .FIELDS_VALID, .FRAME_ERROR, .FRAME_KIND, .FRAME_RATE, .CORE, .BANDWIDTH,
    .CODER_TYPE, .PRIOR_LP, .HQ_RATE_16K, .EXT_FREQ, .PARTIAL_PRESENT, .PARTIAL_TYPE,
    .PARTIAL_OFFSET, .PARTIAL_BITS, .PRIMARY_BITS, .SID_HANGOVER, .SID_FIELD_A,
    .SID_FIELD_B, .SID_FIELD_C);
  frame_sink sink (.clk(SYS_CLK), .rst_n(RST_N), .fields_valid(FIELDS_VALID),
    .frame_error(FRAME_ERROR), .n_good(n_good), .n_bad(n_bad));
  ////////////////////////////////////////////////////////////////
  function automatic logic [63:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {seed, seed ^ 32'hA5A5A5A5};
  endfunction
  task automatic cmp(input string nm, input logic [36:0] e, input logic [36:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single ahb transfer, waits for ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    HSIZE <= 3'h2;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    d = HRDATA;
  endtask
  // header first, trailer last, random between
  task automatic send(input int len, input logic [47:0] hd, input logic [4:0] tl);
    logic b;
    for (int i = 0; i < len; i++) begin
      w = xs();
      b = i < 48 ? hd[47-i] : (i >= len - 5 ? tl[len-1-i] : w[0]);
      @(posedge SYS_CLK);
      BIT_VALID <= 1'b1;
      BIT_DATA <= b;
      BIT_LAST <= i == len - 1;
    end
    @(posedge SYS_CLK);
    BIT_VALID <= 1'b0;
    BIT_LAST <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
  endtask
  ////////////////////////////////////////////////////////////////
  // result watcher against the oldest note
  always @(posedge SYS_CLK) begin
    if (RST_N === 1'b1 && (FIELDS_VALID === 1'b1 || FRAME_ERROR === 1'b1)) begin
      y = '{default: 0};
      if (expq.size() > 0) y = expq.pop_front();
      else y.err = 1'bx;
      cmp("error", 37'(y.err), 37'(FRAME_ERROR));
      if (y.err === 1'b0) begin
        cmp("rate", 37'(y.rate), 37'(FRAME_RATE));
        cmp("kind", 37'(y.kind), 37'(FRAME_KIND));
      end
      if (y.what[0]) begin
        cmp("sid_a", 37'(y.a), 37'(SID_FIELD_A));
        cmp("sid_b", y.b, SID_FIELD_B);
      end
      if (y.what == 2'h1) begin
        cmp("sid_c", 37'(y.c), 37'(SID_FIELD_C));
        cmp("hangover", 37'(y.h), 37'(SID_HANGOVER));
      end
      if (y.what == 2'h2) begin
        cmp("present", 37'(y.pres), 37'(PARTIAL_PRESENT));
        cmp("ptype", 37'(y.typ), 37'(PARTIAL_TYPE));
        cmp("poffset", 37'(y.off), 37'(PARTIAL_OFFSET));
        cmp("pbits", 37'(y.pb), 37'(PARTIAL_BITS));
        cmp("primary", 37'(y.pri), 37'(PRIMARY_BITS));
      end
      // core selection and header fields
      if (y.cores) begin
        cmp("core", 37'(y.core), 37'(CORE));
        cmp("bw", 37'(y.bw), 37'(BANDWIDTH));
        cmp("ct", 37'(y.ct), 37'(CODER_TYPE));
        cmp("prior", 37'(y.prior), 37'(PRIOR_LP));
        cmp("hq16", 37'(y.hq16), 37'(HQ_RATE_16K));
        cmp("ext", 37'(y.ext), 37'(EXT_FREQ));
      end
    end
  end
  task automatic print_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #3000000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    ahb(1'b0, `REG_CTRL, 32'h0);
    cmp("ctrl", 37'h1, 37'(d));
    for (int k = 0; k < 9; k++) begin
      x = '{default: 0};
      x.err = k > 6;
      x.rate = 4'(k); // rate codes follow length order
      w = xs();
      expq.push_back(x);
      send(k > 6 ? 47 + 216 * (k - 7) + 2 * (8 - k) : lens[k], w[47:0], w[52:48]);
    end
    $display("test lengths done");
    for (int s = 0; s < 3; s++) begin
      w = xs();
      x = '{default: 0};
      x.rate = `RATE_SID;
      x.kind = 3'(s + 1);
      x.what = s == 0 ? 2'h3 : 2'h1;
      x.a = w[6:0];
      x.b = s == 0 ? w[43:7] : {8'h0, w[35:7]};
      x.h = w[38:36];
      x.c = s == 1 ? {1'b0, w[44:39]} : {3'h0, w[44:41]};
      x.cores = 1'b1;
      x.bw = s == 0 ? w[47:46] : 2'(s - 1);
      x.hq16 = w[45];
      expq.push_back(x);
      if (s == 0) send(48, {1'b1, w[47:45], x.a, x.b}, 5'h0);
      else send(48, {2'(s - 1), w[45], x.h, w[35:7], x.a, w[44:39]}, 5'h0);
    end
    $display("test descriptors done");
    for (int t = 0; t < 9; t++) begin
      w = xs();
      x = '{default: 0};
      x.rate = `RATE_CA;
      x.kind = `KIND_CA;
      x.what = 2'h2;
      x.pres = t < 8;
      x.typ = t < 8 ? 3'(t) : 3'h0;
      x.off = t < 8 ? offs[t%4] : 3'h0;
      x.cores = 1'b1;
      x.ct = {x.pres, w[46:43]};
      x.pb = x.pres ? pbt[t % 8] : 7'h00;
      x.pri = x.pres ? 9'(`CA_PAYLOAD_BITS - `CA_TRAILER_BITS - x.pb) : 9'h000;
      expq.push_back(x);
      send(264, {x.pres, w[46:0]}, {2'(t % 4), 3'(t)});
    end
    $display("test channel aware done");
    // every core branch at every rate, two rounds of switching bits
    for (int j = 0; j < 24; j++) begin
      w = xs();
      c = j % 12;
      sw = 2'(c / 3 + j / 12); // all four switching pairs over the two rounds
      hd = w[47:0];
      case (c)
        0: hd[44] = 1'b0;
        1: hd[44:43] = 2'b11;
        2: hd[44:41] = {2'b10, sw};
        3, 7: hd[47] = 1'b0;
        4: hd[47:46] = 2'b11;
        5: hd[47:44] = {2'b10, sw};
        8: hd[47:45] = {1'b1, sw};
        default: ;
      endcase
      x = '{default: 0};
      x.cores = 1'b1;
      x.rate = rt[c];
      x.core = c inside {2, 5, 8} ? `CORE_HQ
             : (c inside {0, 3, 7, 11} ? `CORE_LP : `CORE_TRANSFORM);
      x.bw = c inside {3, 4, 5, 7, 8} ? 2'h0 : hd[47:46];
      case (c)
        0: x.ct = 5'(hd[43:42]);
        1: x.ct = 5'(hd[42:41]);
        3, 7: x.ct = 5'(hd[46:43]);
        4: x.ct = 5'(hd[45:44]);
        2, 5, 8: x.ct = 5'h00;
        default: x.ct = 5'(hd[44:42]);
      endcase
      x.prior = c inside {2, 5, 8} && sw[1];
      x.hq16 = c inside {2, 5, 8} && sw == 2'b11;
      x.ext = c == 3 && hd[42];
      expq.push_back(x);
      send(lens[rt[c]], hd, w[52:48]);
    end
    $display("test cores done");
    ahb(1'b0, `REG_FIELDS, 32'h0);
    cmp("fields", 37'({4'h0, x.rate, 1'b0, x.kind, 2'h0, x.core, 2'h0, x.bw, 1'b0, x.ct,
      3'h0, x.prior, x.hq16, x.ext}), 37'(d));
    ahb(1'b0, `REG_FRAMES, 32'h0);
    cmp("frames", 37'd43, 37'(d[15:0]));
    ahb(1'b0, `REG_ERRORS, 32'h0);
    cmp("errors", 37'd2, 37'(d[15:0]));
    cmp("sink", 37'd4302, 37'(n_good * 100 + n_bad));
    ahb(1'b1, `REG_CTRL, 32'h0);
    send(328, 48'h0, 5'h0);
    ahb(1'b0, `REG_FRAMES, 32'h0);
    cmp("disabled", 37'd43, 37'(d[15:0]));
    ahb(1'b1, `REG_CTRL, 32'h3);
    ahb(1'b0, `REG_FRAMES, 32'h0);
    cmp("cleared", 37'h0, 37'(d[15:0]));
    ahb(1'b0, 8'h40, 32'h0);
    cmp("unmapped", 37'h0, 37'(d));
    cmp("left", 37'h0, 37'(expq.size()));
    $display("test registers done");
    print_verdict();
  end
endmodule
bind speech_frame_field_parser frame_parser_props props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .HRESP(HRESP), .HREADYOUT(HREADYOUT), .BIT_VALID(BIT_VALID), .BIT_LAST(BIT_LAST),
  .FIELDS_VALID(FIELDS_VALID), .FRAME_ERROR(FRAME_ERROR), .FRAME_KIND(FRAME_KIND),
  .FRAME_RATE(FRAME_RATE), .PARTIAL_PRESENT(PARTIAL_PRESENT), .PARTIAL_TYPE(PARTIAL_TYPE),
  .PARTIAL_OFFSET(PARTIAL_OFFSET), .PARTIAL_BITS(PARTIAL_BITS));
